// ==== gate_brake_pkg.sv ====
package gate_brake_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET     = 8'h00;
  localparam logic [7:0] BRIDGE_OFFSET   = 8'h04;
  localparam logic [7:0] SINK_OFFSET     = 8'h08;
  localparam logic [7:0] GUARD_OFFSET    = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET   = 8'h10;

  // general_control_reg field positions
  localparam int PUMP_EN_POS     = 0;
  localparam int OC_EN_POS       = 1;
  localparam int RAPID_BRAKE_POS = 2;
  localparam int PARK_EN_POS     = 3;
  localparam int LEVEL_SEL_POS   = 4;
  localparam int STAGE_AUTO_POS  = 5;
  localparam int SPREAD_EN_POS   = 6;
  localparam int EXCLUDE_POS     = 8;
  // bridge register: 2-bit operating select per bridge, then pwm enables
  localparam int PWM_EN_POS      = 8;
  // sink register: regular code, then initial code
  localparam int INIT_CODE_POS   = 8;

  // reset values
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0040;
  localparam logic [31:0] BRIDGE_RESET = 32'h0000_0000;
  localparam logic [31:0] SINK_RESET   = 32'h0000_0000;
  localparam logic [31:0] GUARD_RESET  = 32'h0010_1010;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timing
  localparam int CLK_HZ           = 200_000_000;
  localparam int CLK_PERIOD_NS    = 5;
  localparam int BRAKE_ON_TIME_NS  = 1000;
  localparam int BRAKE_OFF_TIME_NS = 1000;
  localparam int BRAKE_ON_CYC  = (BRAKE_ON_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : BRAKE_ON_TIME_NS / CLK_PERIOD_NS;
  localparam int BRAKE_OFF_CYC = (BRAKE_OFF_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : BRAKE_OFF_TIME_NS / CLK_PERIOD_NS;
  localparam int SPREAD_FREQ_HZ   = 15_600;
  localparam int SPREAD_HALF_CYC  = CLK_HZ / (2 * SPREAD_FREQ_HZ);

  // sink current per 6-bit code, in units of 0.1 mA
  localparam logic [10:0] SINK_TABLE [64] = '{
    11'd5,    11'd7,    11'd10,   11'd14,   11'd18,   11'd24,   11'd30,   11'd38,
    11'd47,   11'd58,   11'd69,   11'd81,   11'd94,   11'd107,  11'd121,  11'd135,
    11'd151,  11'd168,  11'd186,  11'd205,  11'd225,  11'd245,  11'd265,  11'd287,
    11'd309,  11'd332,  11'd357,  11'd382,  11'd408,  11'd434,  11'd461,  11'd488,
    11'd515,  11'd542,  11'd569,  11'd596,  11'd624,  11'd652,  11'd680,  11'd708,
    11'd737,  11'd766,  11'd795,  11'd825,  11'd855,  11'd885,  11'd915,  11'd946,
    11'd977,  11'd1009, 11'd1042, 11'd1075, 11'd1108, 11'd1142, 11'd1176, 11'd1210,
    11'd1245, 11'd1280, 11'd1315, 11'd1351, 11'd1387, 11'd1423, 11'd1458, 11'd1500};

  // device operating modes from the mode controller
  typedef enum logic [2:0] {
    MODE_INIT     = 3'h0,
    MODE_NORMAL   = 3'h1,
    MODE_STOP     = 3'h2,
    MODE_SLEEP    = 3'h3,
    MODE_FAILSAFE = 3'h4,
    MODE_RESTART  = 3'h5
  } dev_mode_type;

  // brake sequence
  typedef enum logic [1:0] {
    BRK_IDLE    = 2'h0,
    BRK_TURNOFF = 2'h1,
    BRK_PUMPOFF = 2'h3,
    BRK_ROUTE   = 2'h2
  } brake_state_type;

endpackage

// ==== gate_brake_ctrl.sv ====
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
// Function
// R1: each 6-bit sink code maps monotonically to a sink current, 36->62.4mA, 63->150mA
// R2: main regulator undervoltage pulls every gate down passively
// R3: in normal mode a bridge with operating select 00 is pulled down
// R4: in normal mode pump disabled or enabled overcurrent pulls gates down
// R5: bridge or internal supply overvoltage pulls gates down, except low-side overvoltage braking
// R6: pump undervoltage, pump blanking and pump overtemperature pull gates down
// R7: in normal mode drain-source overvoltage after active discharge pulls gates down
// R8: all non-normal modes pull gates down, except low-sides used for braking
// R9: the rapid-brake request acts only in normal mode
// R10: rapid brake first actively turns off bridges 01/10 for their guard time
// R11: rapid brake then disables the pump whatever the pump enable bit says; the code turns the pump off as soon as active turn-off starts
// R12: rapid brake then routes the first pwm pin to all low-sides
// R13: routed low-sides follow the pin within brake turn-on and turn-off times
// R14: software may exclude single low-sides from rapid braking
// R15: parking brake on entering sleep or stop turns bridges off, then pump off; the code turns the pump off as soon as the turn-off starts
// R16: parking brake releases low-side pull-downs, keeps high-side ones, low-sides follow pin
// R17: level select picks 11 V or 15 V pump regulation
// R18: with auto stage bit 0 the pump always runs dual stage
// R19: with auto stage bit 1 pump stage follows supply thresholds with hysteresis
// R20: spread bit 1 (default) modulates the pump at 15.6 kHz, 0 leaves it unmodulated
// R21: clearing the rapid-brake request returns to normal gate and pump control
module gate_brake_ctrl
  import gate_brake_pkg::*;
#(
  parameter int SPREAD_HALF = SPREAD_HALF_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // axi4-lite slave
  input  wire logic [7:0]  axi_awaddr_i,
  input  wire logic        axi_awvalid_i,
  output logic             axi_awready_o,
  input  wire logic [31:0] axi_wdata_i,
  input  wire logic [3:0]  axi_wstrb_i,
  input  wire logic        axi_wvalid_i,
  output logic             axi_wready_o,
  output logic [1:0]       axi_bresp_o,
  output logic             axi_bvalid_o,
  input  wire logic        axi_bready_i,
  input  wire logic [7:0]  axi_araddr_i,
  input  wire logic        axi_arvalid_i,
  output logic             axi_arready_o,
  output logic [31:0]      axi_rdata_o,
  output logic [1:0]       axi_rresp_o,
  output logic             axi_rvalid_o,
  input  wire logic        axi_rready_i,
  // device mode and normal gate commands from on-chip logic
  input  wire logic [2:0]  dev_mode_i,
  input  wire logic [2:0]  high_cmd_i,
  input  wire logic [2:0]  low_cmd_i,
  // asynchronous monitors and pin
  input  wire logic        first_pwm_input_pin_i,
  input  wire logic        regulator_uv_i,
  input  wire logic        overcurrent_i,
  input  wire logic        supply_ov_i,
  input  wire logic        ov_brake_i,
  input  wire logic        pump_uv_i,
  input  wire logic        pump_blank_i,
  input  wire logic        pump_overtemperature_i,
  input  wire logic        drain_ov_i,
  input  wire logic        supply_above_upper_i,
  input  wire logic        supply_below_lower_i,
  // gate side
  output logic [2:0]       high_gate_output_o,
  output logic [2:0]       low_gate_output_o,
  output logic [2:0]       high_pulldown_o,
  output logic [2:0]       low_pulldown_o,
  output logic [2:0]       active_off_o,
  output logic [10:0]      sink_current_o,
  output logic [10:0]      init_sink_current_o,
  // charge pump side
  output logic             pump_on_o,
  output logic             pump_high_level_o,
  output logic             pump_single_stage_o,
  output logic             pump_spread_o
);

  ////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers
  localparam int NSYNC = 11;
  logic [1:0]       rst_sync_q;
  logic             rst_n;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  logic             pwm_s, uv_s, oc_s, ov_s, ovbrk_s, puv_s, blank_s, pot_s, dov_s, up_s, lo_s;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // two flops on every asynchronous input
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {first_pwm_input_pin_i, regulator_uv_i, overcurrent_i, supply_ov_i, ov_brake_i,
                 pump_uv_i, pump_blank_i, pump_overtemperature_i, drain_ov_i,
                 supply_above_upper_i, supply_below_lower_i};
      sync_q <= meta_q;
    end
  end
  assign {pwm_s, uv_s, oc_s, ov_s, ovbrk_s, puv_s, blank_s, pot_s, dov_s, up_s, lo_s} = sync_q;

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite register access
  logic [31:0] ctrl_q, bridge_q, sink_q, guard_q;
  logic        aw_hold_q, w_hold_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_fire;
  logic [31:0] status;

  assign axi_awready_o = !aw_hold_q && !axi_bvalid_o;
  assign axi_wready_o  = !w_hold_q && !axi_bvalid_o;
  assign wr_fire       = aw_hold_q && w_hold_q && !axi_bvalid_o;

  // write address and data are caught in either order
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (axi_awvalid_i && axi_awready_o) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= axi_awaddr_i;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
      if (axi_wvalid_i && axi_wready_o) begin
        w_hold_q <= 1'b1;
        wdata_q  <= axi_wdata_i;
        wstrb_q  <= axi_wstrb_i;
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // register writes with byte strobes
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= CTRL_RESET;
      bridge_q <= BRIDGE_RESET;
      sink_q   <= SINK_RESET;
      guard_q  <= GUARD_RESET;
    end else if (wr_fire) begin
      for (int i = 0; i < 4; i++) begin
        if (wstrb_q[i]) begin
          unique case (awaddr_q[7:2])
            CTRL_OFFSET[7:2]:   ctrl_q[i*8 +: 8]   <= wdata_q[i*8 +: 8];
            BRIDGE_OFFSET[7:2]: bridge_q[i*8 +: 8] <= wdata_q[i*8 +: 8];
            SINK_OFFSET[7:2]:   sink_q[i*8 +: 8]   <= wdata_q[i*8 +: 8];
            GUARD_OFFSET[7:2]:  guard_q[i*8 +: 8]  <= wdata_q[i*8 +: 8];
            default: ;
          endcase
        end
      end
    end
  end

  // write response, slverr for an unmapped or read-only word
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      axi_bvalid_o <= 1'b0;
      axi_bresp_o  <= RESP_OKAY;
    end else if (wr_fire) begin
      axi_bvalid_o <= 1'b1;
      axi_bresp_o  <= (awaddr_q[7:2] <= GUARD_OFFSET[7:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_bready_i) begin
      axi_bvalid_o <= 1'b0;
    end
  end

  // read channel, one cycle to answer
  assign axi_arready_o = !axi_rvalid_o;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      axi_rvalid_o <= 1'b0;
      axi_rdata_o  <= 32'h0000_0000;
      axi_rresp_o  <= RESP_OKAY;
    end else if (axi_arvalid_i && axi_arready_o) begin
      axi_rvalid_o <= 1'b1;
      axi_rresp_o  <= RESP_OKAY;
      unique case (axi_araddr_i[7:2])
        CTRL_OFFSET[7:2]:   axi_rdata_o <= ctrl_q;
        BRIDGE_OFFSET[7:2]: axi_rdata_o <= bridge_q;
        SINK_OFFSET[7:2]:   axi_rdata_o <= sink_q;
        GUARD_OFFSET[7:2]:  axi_rdata_o <= guard_q;
        STATUS_OFFSET[7:2]: axi_rdata_o <= status;
        default: begin
          axi_rdata_o <= 32'h0000_0000;
          axi_rresp_o <= RESP_SLVERR;
        end
      endcase
    end else if (axi_rready_i) begin
      axi_rvalid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration fields
  logic       pump_en, oc_en, rapid_req, park_en, level_sel, stage_auto, spread_en;
  logic [2:0] exclude;
  logic [1:0] br_sel [3];
  logic [7:0] guard_cyc [3];
  logic       is_normal, is_rest, was_rest_q;
  dev_mode_type mode;

  assign pump_en    = ctrl_q[PUMP_EN_POS];
  assign oc_en      = ctrl_q[OC_EN_POS];
  assign rapid_req  = ctrl_q[RAPID_BRAKE_POS];
  assign park_en    = ctrl_q[PARK_EN_POS];
  assign level_sel  = ctrl_q[LEVEL_SEL_POS];
  assign stage_auto = ctrl_q[STAGE_AUTO_POS];
  assign spread_en  = ctrl_q[SPREAD_EN_POS];
  assign exclude    = ctrl_q[EXCLUDE_POS +: 3];
  assign mode       = dev_mode_type'(dev_mode_i);
  assign is_normal  = (mode == MODE_NORMAL);
  assign is_rest    = (mode == MODE_SLEEP) || (mode == MODE_STOP);

  // sink current lookup
  assign sink_current_o      = SINK_TABLE[sink_q[5:0]];                 // R1
  assign init_sink_current_o = SINK_TABLE[sink_q[INIT_CODE_POS +: 6]];  // R1

  ////////////////////////////////////////////////////////////////////////
  // brake sequencer
  brake_state_type state_q;
  logic            park_q;
  logic [7:0]      guard_cnt_q;
  logic [7:0]      guard_max;
  logic            park_start, slam_start, brake_end;

  always_comb begin
    guard_max = 8'h00;
    for (int b = 0; b < 3; b++) begin
      if (guard_cyc[b] > guard_max) begin
        guard_max = guard_cyc[b];
      end
    end
  end

  assign park_start = park_en && is_rest && !was_rest_q;               // R15
  assign slam_start = rapid_req && is_normal;                          // R9
  assign brake_end  = park_q ? !is_rest : !(rapid_req && is_normal);   // R21

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      was_rest_q <= 1'b0;
    end else begin
      was_rest_q <= is_rest;
    end
  end

  // idle, active turn-off, pump off, low-side routing
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= BRK_IDLE;
      park_q      <= 1'b0;
      guard_cnt_q <= 8'h00;
    end else begin
      unique case (state_q)
        BRK_IDLE: begin
          guard_cnt_q <= 8'h00;
          if (park_start || slam_start) begin
            state_q <= BRK_TURNOFF;
            park_q  <= park_start;
          end
        end
        BRK_TURNOFF: begin
          guard_cnt_q <= guard_cnt_q + 8'h01;
          if (brake_end) begin
            state_q <= BRK_IDLE;
          end else if (guard_cnt_q + 8'h01 >= guard_max) begin                   // R10
            state_q <= BRK_PUMPOFF;
          end
        end
        BRK_PUMPOFF: begin
          state_q <= brake_end ? BRK_IDLE : BRK_ROUTE;                 // R11
        end
        BRK_ROUTE: begin
          if (brake_end) begin
            state_q <= BRK_IDLE;                                       // R21
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-bridge gate control
  logic [2:0] hs_on_d, ls_on_d, hs_pd_d, ls_pd_d, act_off_d;
  logic       fault_pd, mode_pd, routing;

  assign routing  = (state_q == BRK_ROUTE);
  assign fault_pd = puv_s || blank_s || pot_s;                                       // R6
  assign mode_pd  = !is_normal || !pump_en || (oc_s && oc_en) || dov_s;             // R4 R7 R8

  for (genvar b = 0; b < 3; b++) begin : g_bridge
    assign br_sel[b]    = bridge_q[2*b +: 2];
    assign guard_cyc[b] = guard_q[8*b +: 8];

    always_comb begin
      act_off_d[b] = (state_q == BRK_TURNOFF) && (guard_cnt_q < guard_cyc[b]) &&
                     (br_sel[b] == 2'h1 || br_sel[b] == 2'h2);                       // R10 R15
      if (routing) begin
        hs_pd_d[b] = 1'b1;                                                           // R16
        ls_on_d[b] = pwm_s && (park_q || !exclude[b]);                               // R12 R13 R14 R16
        ls_pd_d[b] = !ls_on_d[b];
        hs_on_d[b] = 1'b0;
      end else begin
        hs_pd_d[b] = fault_pd || mode_pd || ov_s || (is_normal && br_sel[b] == 2'h0); // R3 R5
        ls_pd_d[b] = hs_pd_d[b];
        hs_on_d[b] = high_cmd_i[b] && !hs_pd_d[b] && !act_off_d[b] && state_q == BRK_IDLE;
        ls_on_d[b] = low_cmd_i[b] && !ls_pd_d[b] && !act_off_d[b] && state_q == BRK_IDLE;
      end
      // low-side overvoltage braking keeps the low-sides driven on
      if (ovbrk_s && ov_s) begin
        ls_pd_d[b] = 1'b0;                                                           // R5 R8
        ls_on_d[b] = 1'b1;
      end
      // regulator undervoltage overrides everything
      if (uv_s) begin
        hs_pd_d[b] = 1'b1;                                                           // R2
        ls_pd_d[b] = 1'b1;
        hs_on_d[b] = 1'b0;
        ls_on_d[b] = 1'b0;
        act_off_d[b] = 1'b0;
      end
    end
  end

  // gate outputs come from flops
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      high_gate_output_o <= 3'h0;
      low_gate_output_o  <= 3'h0;
      high_pulldown_o    <= 3'h7;
      low_pulldown_o     <= 3'h7;
      active_off_o       <= 3'h0;
    end else begin
      high_gate_output_o <= hs_on_d;
      low_gate_output_o  <= ls_on_d;
      high_pulldown_o    <= hs_pd_d;
      low_pulldown_o     <= ls_pd_d;
      active_off_o       <= act_off_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // charge pump control
  logic        single_q, spread_q;
  logic [15:0] spread_cnt_q;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pump_on_o         <= 1'b0;
      pump_high_level_o <= 1'b0;
    end else begin
      pump_on_o         <= pump_en && state_q == BRK_IDLE && !uv_s;                  // R11 R15 R21
      pump_high_level_o <= level_sel;                                                // R17
    end
  end

  // stage select with supply hysteresis
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      single_q <= 1'b0;
    end else if (!stage_auto) begin
      single_q <= 1'b0;                                                              // R18
    end else if (up_s) begin
      single_q <= 1'b1;                                                              // R19
    end else if (lo_s) begin
      single_q <= 1'b0;                                                              // R19
    end
  end
  assign pump_single_stage_o = single_q;

  // spread modulation square wave
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      spread_cnt_q <= 16'h0000;
      spread_q     <= 1'b0;
    end else if (!spread_en) begin
      spread_cnt_q <= 16'h0000;
      spread_q     <= 1'b0;                                                          // R20
    end else if (spread_cnt_q >= 16'(SPREAD_HALF - 1)) begin
      spread_cnt_q <= 16'h0000;
      spread_q     <= !spread_q;                                                     // R20
    end else begin
      spread_cnt_q <= spread_cnt_q + 16'h0001;
    end
  end
  assign pump_spread_o = spread_q;

  assign status = {17'h0_0000, single_q, pump_on_o, park_q, 1'b0, state_q[1:0],
                   low_pulldown_o, high_pulldown_o, low_gate_output_o};

  ////////////////////////////////////////////////////////////////////////
  // checks
  localparam int ON_MAX  = BRAKE_ON_CYC;
  localparam int OFF_MAX = BRAKE_OFF_CYC;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence route_pin_high;
    routing && !brake_end && pwm_s && !exclude[2];
  endsequence

  a_uv_all_off:   assert property (uv_s |=> high_pulldown_o == 3'h7 && low_pulldown_o == 3'h7 &&
                                   high_gate_output_o == 3'h0) else $error("gates not off on uv"); // R2
  a_sel_zero_pd:  assert property (is_normal && br_sel[1] == 2'h0 && !routing && !uv_s
                                   |=> high_pulldown_o[1]) else $error("idle bridge not pulled down"); // R3
  a_pump_en_pd:   assert property (is_normal && !pump_en && state_q == BRK_IDLE && !uv_s
                                   |=> high_pulldown_o == 3'h7) else $error("no pulldown with pump off"); // R4
  a_fault_pd:     assert property ((pot_s || puv_s) && state_q == BRK_IDLE
                                   |=> high_pulldown_o == 3'h7) else $error("pump fault without pulldown"); // R6
  a_rest_pd:      assert property (!is_normal && state_q == BRK_IDLE && !(ovbrk_s && ov_s)
                                   |=> low_pulldown_o == 3'h7) else $error("gate free outside normal"); // R8
  a_slam_normal:  assert property (state_q == BRK_IDLE && rapid_req && !is_normal && !park_start
                                   |=> state_q == BRK_IDLE) else $error("slam left normal mode"); // R9
  a_turnoff_ord:  assert property (state_q == BRK_TURNOFF ##1 state_q == BRK_PUMPOFF
                                   |=> !pump_on_o) else $error("pump left on in brake"); // R11
  a_guard_len:    assert property ($rose(state_q == BRK_TURNOFF) && br_sel[2] == 2'h1 && guard_cyc[2] > 8'h01
                                   |=> active_off_o[2]) else $error("no active turn-off"); // R10
  a_route_on:     assert property (route_pin_high |-> ##[1:ON_MAX] low_gate_output_o[2] || uv_s)
                  else $error("low-side late to turn on"); // R13
  a_route_off:    assert property (routing && !brake_end && !pwm_s && !(ovbrk_s && ov_s)
                                   |-> ##[1:OFF_MAX] !low_gate_output_o[2]) else $error("low-side late to turn off"); // R13
  a_exclude_ls:   assert property (routing && !park_q && exclude[0] && !(ovbrk_s && ov_s)
                                   |=> !low_gate_output_o[0]) else $error("excluded low-side driven"); // R14
  a_park_hs_pd:   assert property (routing && park_q && !brake_end |=> high_pulldown_o == 3'h7 &&
                                   high_gate_output_o == 3'h0) else $error("high-side free in park"); // R16
  a_stage_fixed:  assert property (!stage_auto ##1 !stage_auto |-> !pump_single_stage_o)
                  else $error("single stage without auto"); // R18
  a_spread_off:   assert property (!spread_en |=> !pump_spread_o) else $error("spread with bit clear"); // R20
  a_slam_exit:    assert property (routing && !park_q && !rapid_req |=> state_q == BRK_IDLE)
                  else $error("slam not ended"); // R21

endmodule

// ==== bridge_model.sv ====
`timescale 1ns/1ps
// external legs: a gate conducts only when driven and not pulled down
module bridge_model (
  input  wire logic [2:0] high_i,
  input  wire logic [2:0] low_i,
  input  wire logic [2:0] hpd_i,
  input  wire logic [2:0] lpd_i,
  output logic      [2:0] shoot_o
);
  // both switches of one leg conducting at once
  assign shoot_o = high_i & ~hpd_i & low_i & ~lpd_i;
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import gate_brake_pkg::*;
  logic        clk_i, nrst_i, awv, wv, brdy, arv, pin, awr, wrd, bv, arr, rv, pon, plv, pss, psp, sp;
  logic        shot = 1'b0;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat;
  logic [2:0]  mode, hg, lg, hpd, lpd, aoff, shoot, hc;
  logic [9:0]  mon;
  logic [10:0] snk, isnk;
  logic [1:0]  br, rr;
  int          failures, check_count;
  int          fbit[7] = '{0, 1, 2, 4, 5, 6, 7};
  gate_brake_ctrl #(.SPREAD_HALF(8)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .axi_awaddr_i(awa), .axi_awvalid_i(awv),
    .axi_awready_o(awr), .axi_wdata_i(wd), .axi_wstrb_i(4'hf), .axi_wvalid_i(wv), .axi_wready_o(wrd), .axi_bresp_o(br),
    .axi_bvalid_o(bv), .axi_bready_i(brdy), .axi_araddr_i(ara), .axi_arvalid_i(arv), .axi_arready_o(arr),
    .axi_rdata_o(rdat), .axi_rresp_o(rr), .axi_rvalid_o(rv), .axi_rready_i(1'b1), .dev_mode_i(mode),
    .high_cmd_i(hc), .low_cmd_i(3'h0), .first_pwm_input_pin_i(pin), .regulator_uv_i(mon[0]),
    .overcurrent_i(mon[1]), .supply_ov_i(mon[2]), .ov_brake_i(mon[3]), .pump_uv_i(mon[4]), .pump_blank_i(mon[5]),
    .pump_overtemperature_i(mon[6]), .drain_ov_i(mon[7]), .supply_above_upper_i(mon[8]),
    .supply_below_lower_i(mon[9]), .high_gate_output_o(hg), .low_gate_output_o(lg), .high_pulldown_o(hpd),
    .low_pulldown_o(lpd), .active_off_o(aoff), .sink_current_o(snk), .init_sink_current_o(isnk), .pump_on_o(pon),
    .pump_high_level_o(plv), .pump_single_stage_o(pss), .pump_spread_o(psp));
  bridge_model legs_u (.high_i(hg), .low_i(lg), .hpd_i(hpd), .lpd_i(lpd), .shoot_o(shoot));
  // clock and shoot-through latch
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (shoot !== 3'h0) shot <= 1'b1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // both write channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [4:0] t;
    int n;
    @(posedge clk_i);
    {awa, wd, awv, wv, brdy} <= {a, d, 3'h7};
    n = 0;
    do begin
      @(negedge clk_i);
      t = {awr, wrd, bv, br};
      @(posedge clk_i);
      if (t[4]) awv <= 1'b0;
      if (t[3]) wv <= 1'b0;
      n++;
    end while (!t[2] && n < 50);
    brdy <= 1'b0;
    // the response must have been seen, so a timed-out wait counts as a mismatch
    check(32'(t[2:0]), 32'({1'b1, er}));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [35:0] t;
    int n;
    @(posedge clk_i);
    {ara, arv} <= {a, 1'b1};
    n = 0;
    do begin
      @(negedge clk_i);
      t = {arr, rv, rr, rdat};
      @(posedge clk_i);
      if (t[35]) arv <= 1'b0;
      n++;
    end while (!t[34] && n < 50);
    check(t[31:0], ed);
    check(32'(t[34:32]), 32'({1'b1, er}));
  endtask
  task automatic finish_test;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #100us;
    failures++;
    finish_test;
  end
  // main sequence
  initial begin
    {awv, wv, brdy, arv, pin, hc, awa, ara, wd, mon, nrst_i} = '0;
    mode = MODE_NORMAL;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    wt(3);
    check(32'(hpd), 32'h0000_0007);
    // spread wave flips once every eight clocks with the short half period
    sp = psp;
    wt(8);
    check(32'(psp ^ sp), 32'h0000_0001);
    rd(CTRL_OFFSET, 32'h0000_0040, RESP_OKAY);
    wr(SINK_OFFSET, 32'h0000_3f24, RESP_OKAY);
    check(32'({snk, isnk}), 32'h0013_85dc);
    wr(BRIDGE_OFFSET, 32'h0000_0014, RESP_OKAY);
    wr(CTRL_OFFSET, 32'h0000_0043, RESP_OKAY);
    wt(4);
    check(32'(hpd), 32'h0000_0001);
    wr(CTRL_OFFSET, 32'h0000_0042, RESP_OKAY);
    wt(4);
    check(32'(hpd), 32'h0000_0007);
    wr(BRIDGE_OFFSET, 32'h0000_0015, RESP_OKAY);
    wr(CTRL_OFFSET, 32'h0000_0053, RESP_OKAY);
    wt(4);
    check(32'({hpd, plv}), 32'h0000_0001);
    foreach (fbit[i]) begin
      @(posedge clk_i);
      mon <= 10'h001 << fbit[i];
      wt(5);
      check(32'(hpd & lpd), 32'h0000_0007);
      @(posedge clk_i);
      mon <= 10'h100;
      wt(5);
    end
    check(32'({hpd, pss}), 32'h0000_0000);
    wr(CTRL_OFFSET, 32'h0000_0073, RESP_OKAY);
    wt(4);
    check(32'(pss), 32'h0000_0001);
    @(posedge clk_i);
    {mon, pin, hc} <= {10'h200, 1'b1, 3'h7};
    wt(5);
    check(32'(pss), 32'h0000_0000);
    wr(CTRL_OFFSET, 32'h0000_0177, RESP_OKAY);
    wt(2);
    check(32'(aoff), 32'h0000_0007);
    wt(30);
    check(32'({pon, hg, lg}), 32'h0000_0006);
    @(posedge clk_i);
    pin <= 1'b0;
    wt(4);
    check(32'(lg), 32'h0000_0000);
    wr(CTRL_OFFSET, 32'h0000_0073, RESP_OKAY);
    wt(4);
    check(32'({pon, hg}), 32'h0000_000f);
    @(posedge clk_i);
    {mode, pin} <= {MODE_INIT, 1'b1};
    wr(CTRL_OFFSET, 32'h0000_013f, RESP_OKAY);
    wt(4);
    check(32'({hpd, lpd, lg, psp}), 32'h0000_03f0);
    // parking brake on entering stop: high-sides held down, every low-side follows the pin
    @(posedge clk_i);
    mode <= MODE_STOP;
    wt(30);
    check(32'({hpd, lpd, lg, pon}), 32'h0000_038e);
    rd(8'h14, 32'h0000_0000, RESP_SLVERR);
    wr(STATUS_OFFSET, 32'h0000_0000, RESP_SLVERR);
    check(32'(shot), 32'h0000_0000);
    finish_test;
  end
endmodule
